// >>> irq_unit_pkg.sv
// Constants and a helper function shared by the interrupt unit and its arbiter.
// Assumes an 8-bit special-function-register bus from the CPU core.
package irq_unit_pkg;
  // ==========================================
  // Register offsets
  localparam logic [7:0] ADDR_EXT_IRQ_FLAGS    = 8'h91;
  localparam logic [7:0] ADDR_STD_IRQ_ENABLE   = 8'hA8;
  localparam logic [7:0] ADDR_STD_IRQ_PRIORITY = 8'hB8;
  localparam logic [7:0] ADDR_WAKE_IRQ_CONTROL = 8'hD8;
  localparam logic [7:0] ADDR_EXT_IRQ_ENABLE   = 8'hE8;
  localparam logic [7:0] ADDR_EXT_IRQ_PRIORITY = 8'hF8;
  // ==========================================
  // Field positions, masks and fixed read bits
  localparam int         NUM_SRC         = 11;
  localparam int         GLOBAL_GATE_BIT = 7;
  localparam int         WAKE_FLAG_BIT   = 3;
  localparam logic [7:0] STD_EN_MASK     = 8'hBF;
  localparam logic [7:0] STD_PRIO_MASK   = 8'h3F;
  localparam logic [7:0] STD_PRIO_ONES   = 8'h80;
  localparam logic [7:0] EXT_MASK        = 8'h1F;
  localparam logic [7:0] EXT_ONES        = 8'hE0;
  localparam logic [7:0] XFLAG_ONES      = 8'h08;
  localparam logic [7:0] WAKE_ONES       = 8'h40;
  // ==========================================
  // Reset values
  localparam logic [7:0] RST_REG         = 8'h00;
  // ==========================================
  // Source indices in natural order and vectors
  localparam int SRC_PIN_A = 0;
  localparam int SRC_PIN_B = 2;
  localparam logic [7:0] VECTORS [NUM_SRC] = '{8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B,
                                              8'h43, 8'h4B, 8'h53, 8'h5B, 8'h63};
  localparam logic [3:0] NO_SRC  = 4'hF;

  // Lowest index set in a request vector, NO_SRC when empty
  function automatic logic [3:0] first_src(input logic [NUM_SRC-1:0] req);
    logic [3:0] idx;
    idx = NO_SRC;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req[i]) idx = 4'(i);
    end
    return idx;
  endfunction : first_src
endpackage : irq_unit_pkg

// >>> irq_arb_if.sv
// Carrier between the interrupt unit and its priority arbiter.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface irq_arb_if;
  import irq_unit_pkg::*;
  logic [NUM_SRC-1:0] pending;
  logic [NUM_SRC-1:0] high;
  logic               hp_active;
  logic               lp_active;
  logic               take;
  logic [3:0]         src;
  logic               level;
  modport ctrl (output pending, high, hp_active, lp_active, input take, src, level);
  modport arb  (input pending, high, hp_active, lp_active, output take, src, level);
endinterface : irq_arb_if
`default_nettype wire

// >>> irq_arbiter.sv
// Two-level fixed-order interrupt arbiter, purely combinational.
// Assumes pending requests are already gated by their enables.
`timescale 1ns/1ps
`default_nettype none
module irq_arbiter
  import irq_unit_pkg::*;
(
  irq_arb_if.arb a
);
  logic [3:0] hi_src;
  logic [3:0] lo_src;

  // ==========================================
  // Selection
  always_comb begin
    hi_src  = first_src(a.pending & a.high);
    lo_src  = first_src(a.pending & ~a.high);
    a.take  = 1'b0;
    a.src   = NO_SRC;
    a.level = 1'b0;
    if (hi_src != NO_SRC && !a.hp_active) begin
      a.take  = 1'b1;
      a.src   = hi_src;
      a.level = 1'b1;
    end else if (lo_src != NO_SRC && !a.hp_active && !a.lp_active) begin
      a.take  = 1'b1;
      a.src   = lo_src;
    end
  end
endmodule : irq_arbiter
`default_nettype wire

// >>> mcu_interrupt_unit.sv
// Interrupt unit: eleven sources, enables, priorities, vectors.
// Assumes a CPU core on the same clock driving an 8-bit register bus and ack/return pulses.
`timescale 1ns/1ps
`default_nettype none
module mcu_interrupt_unit
  import irq_unit_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  input  wire logic       ext_request_a_n,
  input  wire logic       ext_request_b_n,
  input  wire logic       pin_a_edge_mode,
  input  wire logic       pin_b_edge_mode,
  output logic            pin_a_flag,
  output logic            pin_b_flag,
  input  wire logic       timer_a_overflow,
  input  wire logic       timer_b_overflow,
  input  wire logic       timer_c_overflow,
  input  wire logic       timer_c_external_flag,
  input  wire logic       uart_rx_done,
  input  wire logic       uart_tx_done,
  input  wire logic       adc_done_request,
  input  wire logic       spi_ready_request,
  input  wire logic       radio_packet_ready,
  input  wire logic       radio_addr_hit,
  input  wire logic       wake_event,
  output logic            irq_req,
  output logic      [7:0] irq_vector,
  output logic            irq_level,
  input  wire logic       irq_ack,
  input  wire logic       irq_return
);
  // ==========================================
  // State and local signals
  typedef struct packed {
    logic [7:0] ie;
    logic [7:0] ip;
    logic [7:0] ext_irq_enable;
    logic [7:0] ext_irq_priority;
    logic [3:0] xflag;
    logic       wake;
    logic [3:0] xsrc_d;
    logic [2:0] pa_s;
    logic [2:0] pb_s;
    logic       fa;
    logic       fb;
    logic       hp_act;
    logic       lp_act;
    logic       req;
    logic [7:0] vec;
    logic [3:0] src;
    logic       lvl;
    logic [7:0] rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  irq_arb_if arb_bus ();

  logic [3:0]         xsrc;
  logic [3:0]         xrise;
  logic               wr_xf;
  logic               wr_wk;
  logic               ack_a;
  logic               ack_b;
  logic [NUM_SRC-1:0] flags;
  logic [NUM_SRC-1:0] enables;
  logic [7:0]         rd_val;

  // ==========================================
  // Helpers
  // Next pin flag: edge mode holds a falling edge until its vector is taken
  function automatic logic pin_flag_next(input logic edge_mode,
                                         input logic flag,
                                         input logic taken,
                                         input logic sync_old,
                                         input logic sync_new);
    logic nxt;
    if (edge_mode) begin
      nxt = (flag && !taken) || (sync_old && !sync_new);
    end else begin
      nxt = !sync_new;
    end
    return nxt;
  endfunction : pin_flag_next

  // Extended enable and priority read back with the top three bits set
  function automatic logic [7:0] ext_read(input logic [7:0] val);
    return (val & EXT_MASK) | EXT_ONES;
  endfunction : ext_read

  // Write strobe aimed at one register
  function automatic logic wr_hit(input logic wr, input logic [7:0] addr, input logic [7:0] target);
    return wr && addr == target;
  endfunction : wr_hit

  // ==========================================
  // Arbiter
  irq_arbiter u_arb (
    .a (arb_bus.arb)
  );

  // ==========================================
  // Request gathering
  always_comb begin
    xsrc    = {radio_addr_hit, radio_packet_ready, spi_ready_request, adc_done_request};
    xrise   = xsrc & ~st_r.xsrc_d;
    wr_xf   = wr_hit(sfr_wr, sfr_addr, ADDR_EXT_IRQ_FLAGS);
    wr_wk   = wr_hit(sfr_wr, sfr_addr, ADDR_WAKE_IRQ_CONTROL);
    ack_a   = irq_ack && st_r.req && st_r.src == 4'(SRC_PIN_A);
    ack_b   = irq_ack && st_r.req && st_r.src == 4'(SRC_PIN_B);
    flags   = {st_r.wake, st_r.xflag,
               timer_c_overflow | timer_c_external_flag,
               uart_rx_done | uart_tx_done,
               timer_b_overflow, st_r.fb, timer_a_overflow, st_r.fa};
    enables = {st_r.ext_irq_enable[4:0], st_r.ie[5:0]} & {NUM_SRC{st_r.ie[GLOBAL_GATE_BIT]}};
    arb_bus.pending   = flags & enables;
    arb_bus.high      = {st_r.ext_irq_priority[4:0], st_r.ip[5:0]};
    arb_bus.hp_active = st_r.hp_act;
    arb_bus.lp_active = st_r.lp_act;
  end

  // ==========================================
  // Read mux
  always_comb begin
    case (sfr_addr)
      ADDR_EXT_IRQ_FLAGS:    rd_val = {st_r.xflag, 4'h0} | XFLAG_ONES;
      ADDR_STD_IRQ_ENABLE:   rd_val = st_r.ie & STD_EN_MASK;
      ADDR_STD_IRQ_PRIORITY: rd_val = (st_r.ip & STD_PRIO_MASK) | STD_PRIO_ONES;
      ADDR_WAKE_IRQ_CONTROL: rd_val = ({7'h00, st_r.wake} << WAKE_FLAG_BIT) | WAKE_ONES;
      ADDR_EXT_IRQ_ENABLE:   rd_val = ext_read(st_r.ext_irq_enable);
      ADDR_EXT_IRQ_PRIORITY: rd_val = ext_read(st_r.ext_irq_priority);
      default:               rd_val = 8'h00;
    endcase
  end

  // ==========================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata  = sfr_rd ? rd_val : st_r.rdata;
    st_nxt.xsrc_d = xsrc;
    st_nxt.pa_s   = {st_r.pa_s[1:0], ext_request_a_n};
    st_nxt.pb_s   = {st_r.pb_s[1:0], ext_request_b_n};
    if (sfr_wr) begin
      case (sfr_addr)
        ADDR_STD_IRQ_ENABLE:   st_nxt.ie  = sfr_wdata & STD_EN_MASK;
        ADDR_STD_IRQ_PRIORITY: st_nxt.ip  = sfr_wdata & STD_PRIO_MASK;
        ADDR_EXT_IRQ_ENABLE:   st_nxt.ext_irq_enable = sfr_wdata & EXT_MASK;
        ADDR_EXT_IRQ_PRIORITY: st_nxt.ext_irq_priority = sfr_wdata & EXT_MASK;
        default:               st_nxt.ie  = st_r.ie;
      endcase
    end
    // Software write first, hardware set wins
    if (wr_xf) st_nxt.xflag = sfr_wdata[7:4];
    st_nxt.xflag = st_nxt.xflag | xrise;
    if (wr_wk) st_nxt.wake = sfr_wdata[WAKE_FLAG_BIT];
    if (wake_event) st_nxt.wake = 1'b1;
    // Pin flags: edge mode latches a falling edge until the vector is taken
    st_nxt.fa = pin_flag_next(pin_a_edge_mode, st_r.fa, ack_a, st_r.pa_s[2], st_r.pa_s[1]);
    st_nxt.fb = pin_flag_next(pin_b_edge_mode, st_r.fb, ack_b, st_r.pb_s[2], st_r.pb_s[1]);
    // In-service tracking: a return closes a level before a new entry opens one
    if (irq_return) begin
      if (st_r.hp_act) st_nxt.hp_act = 1'b0;
      else st_nxt.lp_act = 1'b0;
    end
    if (irq_ack && st_r.req) begin
      if (st_r.lvl) st_nxt.hp_act = 1'b1;
      else st_nxt.lp_act = 1'b1;
    end

    st_nxt.req = arb_bus.take && !(irq_ack && st_r.req);
    st_nxt.src = arb_bus.src;
    st_nxt.lvl = arb_bus.level;
    st_nxt.vec = st_nxt.req ? VECTORS[arb_bus.src] : 8'h00;
  end

  // ==========================================
  // State register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r      <= '0;
      st_r.ie   <= RST_REG;
      st_r.pa_s <= 3'h7;
      st_r.pb_s <= 3'h7;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================
  // Outputs
  assign sfr_rdata  = st_r.rdata;
  assign pin_a_flag = st_r.fa;
  assign pin_b_flag = st_r.fb;
  assign irq_req    = st_r.req;
  assign irq_vector = st_r.vec;
  assign irq_level  = st_r.lvl;
endmodule : mcu_interrupt_unit
`default_nettype wire

// >>> irq_unit_chk.sv
// Port checker for the interrupt unit.
// Assumes it is bound to the unit's top module.
`timescale 1ns/1ps
`default_nettype none
module irq_unit_chk
  import irq_unit_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic       ext_request_a_n,
  input wire logic       pin_a_edge_mode,
  input wire logic       pin_a_flag,
  input wire logic       irq_req,
  input wire logic [7:0] irq_vector,
  input wire logic       irq_level,
  input wire logic       irq_ack,
  input wire logic       irq_return
);
  typedef struct packed {logic gate; logic hp; logic lp;} chk_st_t;
  chk_st_t st_r;
  chk_st_t st_nxt;
  // Gate copy and active service levels
  always_comb begin
    st_nxt = st_r;
    if (sfr_wr && sfr_addr == ADDR_STD_IRQ_ENABLE) st_nxt.gate = sfr_wdata[GLOBAL_GATE_BIT];
    if (irq_return && st_r.hp) st_nxt.hp = 1'b0;
    if (irq_return && !st_r.hp) st_nxt.lp = 1'b0;
    if (irq_req && irq_ack) st_nxt.hp = st_nxt.hp | irq_level;
    if (irq_req && irq_ack) st_nxt.lp = st_nxt.lp | !irq_level;
  end
  always_ff @(posedge clk) begin
    if (!rst_b) st_r <= '0;
    else st_r <= st_nxt;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_gate_blocks: assert property (!$past(st_r.gate) |-> !irq_req)
    else $error("request with gate closed");
  a_vector_legal: assert property (irq_req |-> irq_vector inside {
    8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B, 8'h43, 8'h4B, 8'h53, 8'h5B, 8'h63}) else $error("bad vector");
  a_ack_drops_req: assert property (irq_req && irq_ack |=> !irq_req)
    else $error("request stood after ack");
  a_high_blocks_all: assert property (st_r.hp |-> !irq_req)
    else $error("request during high routine");
  a_low_blocks_low: assert property (st_r.lp |-> !irq_req || irq_level)
    else $error("low request during routine");
  a_prio_fixed_bits: assert property (sfr_rd && sfr_addr == ADDR_STD_IRQ_PRIORITY |=>
    sfr_rdata[7:6] == 2'b10) else $error("priority fixed bits wrong");
  a_enable_bit_six: assert property ($past(sfr_rd && sfr_addr == ADDR_STD_IRQ_ENABLE) |->
    !sfr_rdata[6]) else $error("enable bit 6 set");
  a_flags_low_bits: assert property (sfr_rd && sfr_addr == ADDR_EXT_IRQ_FLAGS |=>
    sfr_rdata[3:0] == 4'h8) else $error("flag low bits wrong");
  a_pin_a_level: assert property ((!ext_request_a_n && !pin_a_edge_mode) [*4] |-> pin_a_flag)
    else $error("level pin flag missing");
endmodule : irq_unit_chk
bind mcu_interrupt_unit irq_unit_chk u_irq_unit_chk (
  .clk(clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
  .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .ext_request_a_n(ext_request_a_n),
  .pin_a_edge_mode(pin_a_edge_mode), .pin_a_flag(pin_a_flag), .irq_req(irq_req),
  .irq_vector(irq_vector), .irq_level(irq_level), .irq_ack(irq_ack), .irq_return(irq_return));
`default_nettype wire

// >>> cpu_model.sv
// CPU core model: acks requests and runs nested service routines.
// Assumes the unit's request port on the same clock.
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       arm,
  input  wire logic [3:0] ack_dly,
  input  wire logic       irq_req,
  input  wire logic       irq_level,
  output logic            irq_ack = 1'b0,
  output logic            irq_return = 1'b0,
  output logic      [3:0] ack_cnt
);
  logic [3:0] wait_cnt;
  logic [7:0] hi_cnt;
  logic [7:0] lo_cnt;
  wire logic  take = arm && irq_req && !irq_ack;
  always @(posedge clk) begin
    irq_ack <= 1'b0;
    irq_return <= 1'b0;
    wait_cnt <= take ? wait_cnt + 4'h1 : 4'h0;
    if (!rst_b) begin
      hi_cnt <= 8'h00;
      lo_cnt <= 8'h00;
      ack_cnt <= 4'h0;
      wait_cnt <= 4'h0;
    end else if (take && wait_cnt >= ack_dly) begin
      irq_ack <= 1'b1;
      ack_cnt <= ack_cnt + 4'h1;
      if (irq_level) hi_cnt <= 8'h28;
      else lo_cnt <= 8'h28;
    end else if (hi_cnt != 8'h00) begin
      hi_cnt <= hi_cnt - 8'h01;
      irq_return <= hi_cnt == 8'h01;
    end else if (lo_cnt != 8'h00) begin
      lo_cnt <= lo_cnt - 8'h01;
      irq_return <= lo_cnt == 8'h01;
    end
  end
endmodule : cpu_model
`default_nettype wire

// >>> tb_top.sv
// Testbench: registers, vectors, gating, order and nesting.
// Assumes the unit, its checker and the CPU model compile first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import irq_unit_pkg::*;
  localparam logic [7:0] REGS [7] = '{8'h91, 8'hA8, 8'hB8, 8'hD8, 8'hE8, 8'hF8, 8'h90};
  localparam logic [7:0] RSTV [7] = '{8'h08, 8'h00, 8'h80, 8'h40, 8'hE0, 8'hE0, 8'h00};
  localparam logic [7:0] ONEV [7] = '{8'hF8, 8'hBF, 8'hBF, 8'h48, 8'hFF, 8'hFF, 8'h00};
  logic        clk = 1'b0, rst_b = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, alt = 1'b0, arm = 1'b0;
  logic [3:0]  dly = 4'h0;
  logic [10:0] src = '0;
  logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00;
  logic [7:0]  sfr_rdata, irq_vector;
  logic [3:0]  ack_cnt;
  logic        pin_a_flag, pin_b_flag, irq_req, irq_level, irq_ack, irq_return;
  int          err_total = 0;
  int          comparisons = 0;
  always #12.5 clk = ~clk;
  mcu_interrupt_unit u_mcu_interrupt_unit (
    .clk(clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .ext_request_a_n(~src[0]), .ext_request_b_n(~src[2]),
    .pin_a_edge_mode(1'b0), .pin_b_edge_mode(1'b1), .pin_a_flag(pin_a_flag), .pin_b_flag(pin_b_flag),
    .timer_a_overflow(src[1]), .timer_b_overflow(src[3]), .timer_c_overflow(src[5] & ~alt),
    .timer_c_external_flag(src[5] & alt), .uart_rx_done(src[4] & ~alt), .uart_tx_done(src[4] & alt),
    .adc_done_request(src[6]), .spi_ready_request(src[7]), .radio_packet_ready(src[8]),
    .radio_addr_hit(src[9]), .wake_event(src[10]), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_level(irq_level), .irq_ack(irq_ack), .irq_return(irq_return));
  cpu_model u_cpu_model (.clk(clk), .rst_b(rst_b), .arm(arm), .ack_dly(dly), .irq_req(irq_req),
    .irq_level(irq_level), .irq_ack(irq_ack), .irq_return(irq_return), .ack_cnt(ack_cnt));
  // ==========================================
  // Access and compare tasks
  task automatic tick;
    @(posedge clk);
    #2;
  endtask : tick
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      err_total++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    tick;
    sfr_wr = 1'b0;
    tick;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr = a;
    sfr_rd = 1'b1;
    tick;
    sfr_rd = 1'b0;
    chk(sfr_rdata, exp);
    tick;
  endtask : rd
  task automatic want(input logic by_ack, input logic [7:0] vec, input logic lvl);
    int n;
    n = 0;
    tick;
    while ((by_ack ? irq_ack : irq_req) !== 1'b1 && n < 20) begin
      tick;
      n++;
    end
    if ((by_ack ? irq_ack : irq_req) !== 1'b1) begin
      $display("[FAIL] %0t no request seen", $time);
      err_total++;
      test_done;
    end else begin
      chk(irq_vector, vec);
      chk({7'h00, irq_level}, {7'h00, lvl});
    end
  endtask : want
  task automatic test_done;
    $display("err_total %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  initial begin
    int i;
    repeat (12) tick;
    rst_b = 1'b1;
    foreach (REGS[k]) rd(REGS[k], RSTV[k]);
    foreach (REGS[k]) wr(REGS[k], 8'hFF);
    foreach (REGS[k]) rd(REGS[k], ONEV[k]);
    foreach (REGS[k]) wr(REGS[k], 8'h00);
    for (int j = 0; j < 13; j++) begin
      i = (j < 11) ? j : j - 7;
      alt = (j > 10);
      wr(ADDR_STD_IRQ_PRIORITY, (i < 6 && i % 2 == 1) ? 8'(1 << i) : 8'h00);
      wr(ADDR_EXT_IRQ_PRIORITY, (i > 5 && i % 2 == 1) ? 8'(1 << (i - 6)) : 8'h00);
      wr(ADDR_EXT_IRQ_ENABLE, (i > 5) ? 8'(1 << (i - 6)) : 8'h00);
      wr(ADDR_STD_IRQ_ENABLE, (i < 6) ? 8'(8'h80 | (1 << i)) : 8'h80);
      src[i] = 1'b1;
      want(1'b0, VECTORS[i], i % 2 == 1);
      src[i] = 1'b0;
      wr(ADDR_EXT_IRQ_FLAGS, 8'h00);
      wr(ADDR_WAKE_IRQ_CONTROL, 8'h00);
      wr(ADDR_STD_IRQ_ENABLE, 8'h00);
    end
    chk({6'h00, pin_b_flag, pin_a_flag}, 8'h02);
    wr(ADDR_EXT_IRQ_ENABLE, 8'h08);
    wr(ADDR_STD_IRQ_ENABLE, 8'h3F);
    src[6] = 1'b1;
    wr(ADDR_EXT_IRQ_FLAGS, 8'h00);
    rd(ADDR_EXT_IRQ_FLAGS, 8'h18);
    wr(ADDR_EXT_IRQ_FLAGS, 8'h00);
    rd(ADDR_EXT_IRQ_FLAGS, 8'h08);
    src[6] = 1'b0;
    wr(ADDR_EXT_IRQ_FLAGS, 8'h80);
    rd(ADDR_EXT_IRQ_FLAGS, 8'h88);
    repeat (8) begin
      tick;
      chk({7'h00, irq_req}, 8'h00);
    end
    wr(ADDR_STD_IRQ_ENABLE, 8'h80);
    want(1'b0, 8'h5B, 1'b0);
    wr(ADDR_EXT_IRQ_FLAGS, 8'h00);
    wr(ADDR_STD_IRQ_ENABLE, 8'h8A);
    src[3] = 1'b1;
    src[1] = 1'b1;
    want(1'b0, 8'h0B, 1'b0);
    wr(ADDR_STD_IRQ_PRIORITY, 8'h08);
    want(1'b0, 8'h1B, 1'b1);
    src = '0;
    wr(ADDR_STD_IRQ_PRIORITY, 8'h00);
    wr(ADDR_EXT_IRQ_PRIORITY, 8'h10);
    wr(ADDR_EXT_IRQ_ENABLE, 8'h10);
    wr(ADDR_STD_IRQ_ENABLE, 8'h82);
    arm = 1'b1;
    src[1] = 1'b1;
    want(1'b1, 8'h0B, 1'b0);
    src[1] = 1'b0;
    dly = 4'h3;
    src[10] = 1'b1;
    want(1'b1, 8'h63, 1'b1);
    src[10] = 1'b0;
    wr(ADDR_WAKE_IRQ_CONTROL, 8'h00);
    repeat (100) tick;
    chk({4'h0, ack_cnt}, 8'h02);
    wr(ADDR_STD_IRQ_ENABLE, 8'h84);
    want(1'b1, 8'h13, 1'b0);
    repeat (2) tick;
    chk({6'h00, pin_b_flag, pin_a_flag}, 8'h00);
    test_done;
  end
endmodule : tb_top
`default_nettype wire
